/* hdl/ppio_pad_mux.sv */
// Per-bit output source select and driver mode for one port
`timescale 1ns/1ps
module ppio_pad_mux (
  input wire logic [15:0] latch_i,
  input wire logic [15:0] dir_i,
  input wire logic [15:0] od_i,
  input wire logic [15:0] alt_i,
  input wire logic [15:0] alt_out_i,
  input wire logic [15:0] alt_oe_i,
  input wire logic [15:0] ovr_en_i,
  input wire logic [15:0] ovr_out_i,
  input wire logic [15:0] ovr_oe_i,
  output logic [15:0] out_o,
  output logic [15:0] oe_n_o
);
  import ppio_pkg::*;

  for (genvar b = 0; b < PW; b++) begin : g_bit
    logic val;
    logic drv;
    logic od;
    // Override (external bus, or segment address on port 4) wins over alternate, alternate over latch
    assign val = ovr_en_i[b] ? ovr_out_i[b] :
                 alt_i[b] ? alt_out_i[b] : latch_i[b];
    assign drv = ovr_en_i[b] ? ovr_oe_i[b] :
                 alt_i[b] ? alt_oe_i[b] : dir_i[b];
    assign od = od_i[b] && !ovr_en_i[b];
    assign out_o[b] = val;
    // Input mode floats; open-drain is ignored under override, otherwise never drives high
    assign oe_n_o[b] = !(drv && !(od && val));
  end
endmodule : ppio_pad_mux

/* hdl/ppio_pkg.sv */
// Constants and register map of the parallel port block
package ppio_pkg;
  localparam int NPORT = 9;
  localparam int PW = 16;
  localparam int NPIN = NPORT * PW;
  // Register index within a port window
  localparam logic [2:0] REG_LATCH = 3'h0;
  localparam logic [2:0] REG_DIR = 3'h1;
  localparam logic [2:0] REG_OD = 3'h2;
  localparam logic [2:0] REG_ALT = 3'h3;
  localparam logic [2:0] REG_IN = 3'h4;
  localparam logic [2:0] REG_BIT = 3'h5;
  localparam logic [2:0] REG_THR = 3'h6;
  localparam logic [11:0] ADR_EDGE = 12'h200;
  localparam logic [11:0] ADR_MODE = 12'h204;
  // Field positions
  localparam int EDGE_BUS_POS = 0;
  localparam int EDGE_NONBUS_POS = 4;
  localparam int MODE_BUS_POS = 0;
  localparam int MODE_SEG_POS = 1;
  localparam int BITW_VAL_POS = 4;
  // Port capability masks, one bit per port
  localparam logic [8:0] OD_PORTS = 9'h0DC;
  localparam logic [8:0] THR_PORTS = 9'h1CC;
  localparam logic [8:0] IN_ONLY_PORTS = 9'h020;
  localparam int SEG_PORT = 4;
  localparam int SEG_W = 8;
  // Reset values
  localparam logic [15:0] DIR_RST = 16'h0000;
  localparam logic [15:0] LATCH_RST = 16'h0000;
  localparam logic [15:0] OE_N_RST = 16'hFFFF;
  localparam logic [1:0] EDGE_RST = 2'h0;
  localparam logic [1:0] MODE_RST = 2'h0;
endpackage : ppio_pkg

/* hdl/ppio_top.sv */
// Parallel port block: registers, pin drivers, bus and alternate sharing
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module ppio_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic [ppio_pkg::NPIN-1:0] pin_in_i,
  output logic [ppio_pkg::NPIN-1:0] pin_out_o,
  output logic [ppio_pkg::NPIN-1:0] pin_oe_n_o,
  input wire logic [ppio_pkg::NPIN-1:0] alt_out_i,
  input wire logic [ppio_pkg::NPIN-1:0] alt_oe_i,
  input wire logic [31:0] bus_ad_out_i,
  input wire logic [31:0] bus_ad_oe_i,
  input wire logic [ppio_pkg::SEG_W-1:0] seg_addr_i,
  output logic [2*ppio_pkg::NPORT-1:0] thresh_cmos_o,
  output logic edge_bus_slow_o,
  output logic edge_nonbus_slow_o,
  output logic bus_mode_o,
  output logic seg_mode_o
);
  import ppio_pkg::*;

  typedef struct packed {
    logic [NPORT-1:0][PW-1:0] latch;
    logic [NPORT-1:0][PW-1:0] dir;
    logic [NPORT-1:0][PW-1:0] od;
    logic [NPORT-1:0][PW-1:0] alt;
    logic [NPORT-1:0][1:0] thr;
    logic [1:0] edge_sel;
    logic [1:0] mode;
    logic [NPORT-1:0][PW-1:0] pin_out;
    logic [NPORT-1:0][PW-1:0] pin_oe_n;
  } ppio_state_t;

  ppio_state_t s_reg, s_next;
  logic wr_stb;
  logic [31:0] rdata;
  logic [3:0] pidx;
  logic [2:0] ridx;
  logic port_hit;
  logic [NPORT-1:0][PW-1:0] pad_out;
  logic [NPORT-1:0][PW-1:0] pad_oe_n;
  logic [NPORT-1:0][PW-1:0] pin_in;

  assign pidx = wb_adr_i[8:5];
  assign ridx = wb_adr_i[4:2];
  assign port_hit = (wb_adr_i[11:9] == 3'h0) && (pidx < 4'(NPORT));
  assign pin_in = pin_in_i;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = dat[15:8];
    end
  endfunction : merge16

  ppio_wb_slave u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .rdata_i(rdata),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .wr_stb_o(wr_stb)
  );

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (port_hit) begin
      case (ridx)
        REG_LATCH, REG_BIT: rdata[15:0] = s_reg.latch[pidx];
        REG_DIR: rdata[15:0] = s_reg.dir[pidx];
        REG_OD: rdata[15:0] = s_reg.od[pidx];
        REG_ALT: rdata[15:0] = s_reg.alt[pidx];
        REG_IN: rdata[15:0] = pin_in[pidx];
        REG_THR: rdata[1:0] = s_reg.thr[pidx];
        default: rdata = 32'h0000_0000;
      endcase
    end else if (wb_adr_i == ADR_EDGE) begin
      rdata[EDGE_BUS_POS] = s_reg.edge_sel[0];
      rdata[EDGE_NONBUS_POS] = s_reg.edge_sel[1];
    end else if (wb_adr_i == ADR_MODE) begin
      rdata[MODE_BUS_POS] = s_reg.mode[0];
      rdata[MODE_SEG_POS] = s_reg.mode[1];
    end
  end

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic [15:0] ovr_en;
    logic [15:0] ovr_out;
    logic [15:0] ovr_oe;
    if (p < 2) begin : g_bus
      assign ovr_en = {PW{s_reg.mode[0]}};
      assign ovr_out = bus_ad_out_i[p*PW +: PW];
      assign ovr_oe = bus_ad_oe_i[p*PW +: PW];
    end else if (p == SEG_PORT) begin : g_seg
      // Segment bits always driven while segmentation is on
      assign ovr_en = {8'h00, {SEG_W{s_reg.mode[1]}}};
      assign ovr_out = {8'h00, seg_addr_i};
      assign ovr_oe = 16'h00FF;
    end else begin : g_none
      assign ovr_en = 16'h0000;
      assign ovr_out = 16'h0000;
      assign ovr_oe = 16'h0000;
    end
    ppio_pad_mux u_pad (
      .latch_i(s_reg.latch[p]),
      .dir_i(s_reg.dir[p]),
      .od_i(s_reg.od[p]),
      .alt_i(s_reg.alt[p]),
      .alt_out_i(alt_out_i[p*PW +: PW]),
      // Input-only port never drives, even from its alternate
      .alt_oe_i(IN_ONLY_PORTS[p] ? 16'h0000 : alt_oe_i[p*PW +: PW]),
      .ovr_en_i(ovr_en),
      .ovr_out_i(ovr_out),
      .ovr_oe_i(ovr_oe),
      .out_o(pad_out[p]),
      .oe_n_o(pad_oe_n[p])
    );
  end

  always_comb begin
    s_next = s_reg;
    if (wr_stb && port_hit) begin
      case (ridx)
        REG_LATCH: begin
          s_next.latch[pidx] = merge16(s_reg.latch[pidx], wb_dat_i, wb_sel_i);
        end
        REG_DIR: begin
          if (!IN_ONLY_PORTS[pidx]) begin
            s_next.dir[pidx] = merge16(s_reg.dir[pidx], wb_dat_i,
                                       wb_sel_i);
          end
        end
        REG_OD: begin
          if (OD_PORTS[pidx]) begin
            s_next.od[pidx] = merge16(s_reg.od[pidx], wb_dat_i,
                                      wb_sel_i);
          end
        end
        REG_ALT: begin
          s_next.alt[pidx] = merge16(s_reg.alt[pidx], wb_dat_i,
                                     wb_sel_i);
        end
        REG_BIT: begin
          if (wb_sel_i[0]) begin
            s_next.latch[pidx][wb_dat_i[3:0]] = wb_dat_i[BITW_VAL_POS];
          end
        end
        REG_THR: begin
          if (THR_PORTS[pidx] && wb_sel_i[0]) begin
            s_next.thr[pidx] = wb_dat_i[1:0];
          end
        end
        default: begin
        end
      endcase
    end else if (wr_stb && wb_adr_i == ADR_EDGE && wb_sel_i[0]) begin
      s_next.edge_sel = {wb_dat_i[EDGE_NONBUS_POS],
                         wb_dat_i[EDGE_BUS_POS]};
    end else if (wr_stb && wb_adr_i == ADR_MODE && wb_sel_i[0]) begin
      s_next.mode = {wb_dat_i[MODE_SEG_POS], wb_dat_i[MODE_BUS_POS]};
    end
    s_next.pin_out = pad_out;
    s_next.pin_oe_n = pad_oe_n;
    if (rst_i) begin
      s_next.latch = {NPORT{LATCH_RST}};
      s_next.dir = {NPORT{DIR_RST}};
      s_next.od = '0;
      s_next.alt = '0;
      s_next.thr = '0;
      s_next.edge_sel = EDGE_RST;
      s_next.mode = MODE_RST;
      s_next.pin_out = '0;
      s_next.pin_oe_n = {NPORT{OE_N_RST}};
    end
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  assign pin_out_o = s_reg.pin_out;
  assign pin_oe_n_o = s_reg.pin_oe_n;
  assign thresh_cmos_o = s_reg.thr;
  assign edge_bus_slow_o = s_reg.edge_sel[0];
  assign edge_nonbus_slow_o = s_reg.edge_sel[1];
  assign bus_mode_o = s_reg.mode[0];
  assign seg_mode_o = s_reg.mode[1];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_RESET_INPUTS: assert property (
    @(posedge clk_i) disable iff (1'b0)
    rst_i |=> (pin_oe_n_o == {NPIN{1'b1}}) && (s_reg.dir == '0))
    else $error("pin driven after reset");
  AST_INPUT_FLOATS: assert property (
    (!s_reg.dir[2][0] && !s_reg.alt[2][0]) |=> pin_oe_n_o[32])
    else $error("input pin not floating");
  AST_OD_NO_HIGH: assert property (
    (s_reg.od[2][1] && s_reg.latch[2][1] && !s_reg.alt[2][1])
    |=> pin_oe_n_o[33])
    else $error("open-drain pin driven high");
  AST_PUSH_PULL: assert property (
    (s_reg.dir[2][0] && !s_reg.od[2][0] && !s_reg.alt[2][0])
    |=> !pin_oe_n_o[32] && pin_out_o[32] == $past(s_reg.latch[2][0]))
    else $error("output pin not driving latch");
  AST_BIT_ALONE: assert property (
    (wr_stb && port_hit && ridx == REG_BIT && pidx == 4'h2 && wb_sel_i[0])
    |=> ((s_reg.latch[2] ^ $past(s_reg.latch[2]))
         & ~(16'h0001 << $past(wb_dat_i[3:0]))) == 16'h0000)
    else $error("bit write disturbed other bits");
  AST_EDGE_WRITE: assert property (
    (wr_stb && wb_adr_i == ADR_EDGE && wb_sel_i[0])
    ##1 1'b1 ##1 1'b1 |-> edge_bus_slow_o == $past(wb_dat_i[0], 2)
    && edge_nonbus_slow_o == $past(wb_dat_i[4], 2))
    else $error("edge-rate bits not taken");
  AST_THR_PORTS: assert property (
    thresh_cmos_o[1:0] == 2'h0 && thresh_cmos_o[3:2] == 2'h0
    && thresh_cmos_o[11:8] == 4'h0)
    else $error("threshold set on unsupported port");
  AST_BUS_LINES: assert property (
    s_reg.mode[0] |=> pin_out_o[15:0] == $past(bus_ad_out_i[15:0])
    && pin_oe_n_o[15:0] == ~$past(bus_ad_oe_i[15:0]))
    else $error("port 0 not following external bus");
  AST_SEG_ADDR: assert property (
    s_reg.mode[1] |=> pin_out_o[71:64] == $past(seg_addr_i)
    && pin_oe_n_o[71:64] == 8'h00)
    else $error("segment address not on port 4");
  AST_ALT_OUT: assert property (
    (s_reg.alt[6][0] && !s_reg.od[6][0])
    |=> pin_out_o[96] == $past(alt_out_i[96])
    && pin_oe_n_o[96] == !$past(alt_oe_i[96]))
    else $error("alternate output not on pin");
endmodule : ppio_top

/* hdl/ppio_wb_slave.sv */
// Classic Wishbone slave handshake with registered read data
`timescale 1ns/1ps
module ppio_wb_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] rdata_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic wr_stb_o
);
  import ppio_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } ppio_wb_state_t;

  ppio_wb_state_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !s_reg.ack) begin
      s_next.ack = 1'b1;
      s_next.dat = wb_we_i ? 32'h0000_0000 : rdata_i;
    end
    if (rst_i) begin
      s_next = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  // Write lands on the edge where the master sees ack
  assign wr_stb_o = wb_cyc_i && wb_stb_i && wb_we_i && s_reg.ack;
  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.dat;

  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.ack |=> !s_reg.ack)
    else $error("ack held longer than one cycle");
endmodule : ppio_wb_slave

/* tb/ppio_board.sv */
// Board model: resolves every pin from the block's drivers
`timescale 1ns/1ps
module ppio_board (
  input wire logic [ppio_pkg::NPIN-1:0] pin_out_i,
  input wire logic [ppio_pkg::NPIN-1:0] pin_oe_n_i,
  output logic [ppio_pkg::NPIN-1:0] pin_in_o
);
  import ppio_pkg::*;
  // Pull-ups on every line, so a released pin never echoes old data
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pin_in_o[i] = (pin_oe_n_i[i] === 1'b0) ? pin_out_i[i] : 1'b1;
    end
  end
endmodule : ppio_board

/* tb/tb_ppio_top.sv */
// Self-checking bench for the parallel port block
`timescale 1ns/1ps
module tb_ppio_top;
  import ppio_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, ack_dat, bus_out = 32'h0, bus_oe = 32'h0;
  logic ack;
  logic [31:0] rdat;
  logic [NPIN-1:0] pin_in, pin_out, oe_n, alt_out = '0, alt_oe = '0;
  logic [7:0] seg = 8'h00;
  logic [17:0] thr;
  logic eb, en, bm, sm;
  int err_total = 0, n_compared = 0;
  always #5 clk_i = ~clk_i;
  ppio_top u_ppio_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat), .pin_in_i(pin_in),
    .pin_out_o(pin_out), .pin_oe_n_o(oe_n), .alt_out_i(alt_out),
    .alt_oe_i(alt_oe), .bus_ad_out_i(bus_out), .bus_ad_oe_i(bus_oe),
    .seg_addr_i(seg), .thresh_cmos_o(thr), .edge_bus_slow_o(eb),
    .edge_nonbus_slow_o(en), .bus_mode_o(bm), .seg_mode_o(sm));
  ppio_board u_ppio_board (.pin_out_i(pin_out), .pin_oe_n_i(oe_n),
    .pin_in_o(pin_in));
  task automatic chk(string name, logic [NPIN-1:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Ack sampled at the rising edge; request held until that edge
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'h3;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 1'b0, 1'b1);
    ack_dat = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic rd(logic [11:0] a, logic [31:0] exp, string name);
    bus(1'b0, a, 32'h0);
    chk(name, ack_dat, exp);
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask : settle
  task automatic s_reset;
    chk("oe_n", oe_n, {NPIN{1'b1}});
    chk("out", pin_out, '0);
    rd(ADR_EDGE, 32'h0, "edge rst");
    rd(12'h044, 32'h0, "dir rst");
  endtask : s_reset
  task automatic s_dir;
    bus(1'b1, 12'h040, 32'hA5C3);
    bus(1'b1, 12'h044, 32'h00FF);
    settle;
    chk("p2 oe_n", oe_n[32+:16], 16'hFF00);
    chk("p2 out", pin_out[32+:8], 8'hC3);
    rd(12'h050, 32'hFFC3, "p2 in");
  endtask : s_dir
  task automatic s_bit;
    bus(1'b1, 12'h054, 32'h1E);
    bus(1'b1, 12'h054, 32'h00);
    rd(12'h040, 32'hE5C2, "bit wr");
  endtask : s_bit
  task automatic s_od;
    bus(1'b1, 12'h048, 32'hFFFF);
    bus(1'b1, 12'h100, 32'h0001);
    bus(1'b1, 12'h104, 32'h0001);
    bus(1'b1, 12'h108, 32'h0001);
    settle;
    chk("p2 od", oe_n[32+:16], 16'hFFC2);
    chk("p8 pp", oe_n[128+:16], 16'hFFFE);
    bus(1'b1, 12'h0A4, 32'hFFFF);
    settle;
    chk("p5 in", oe_n[80+:16], 16'hFFFF);
  endtask : s_od
  task automatic s_thr;
    for (int p = 0; p < NPORT; p++) bus(1'b1, 12'(p * 32 + 24), 32'h3);
    settle;
    chk("thr all", thr, 18'h3F0F0);
    bus(1'b1, 12'h058, 32'h1);
    settle;
    chk("thr p2", thr, 18'h3F0D0);
  endtask : s_thr
  task automatic s_edge;
    bus(1'b1, ADR_EDGE, 32'h01);
    settle;
    chk("edge", {eb, en}, 2'b10);
    bus(1'b1, ADR_EDGE, 32'h10);
    settle;
    chk("edge", {eb, en}, 2'b01);
    rd(ADR_EDGE, 32'h10, "edge rd");
  endtask : s_edge
  task automatic s_bus;
    bus_out <= 32'hCAFEBEEF; bus_oe <= 32'hFFFFFFFF; seg <= 8'h5A;
    bus(1'b1, ADR_MODE, 32'h1);
    settle;
    chk("ad out", pin_out[31:0], 32'hCAFEBEEF);
    chk("ad oe", oe_n[31:0], 32'h0);
    chk("mode", {bm, sm}, 2'b10);
    bus(1'b1, ADR_MODE, 32'h3);
    settle;
    chk("seg", {pin_out[64+:8], oe_n[64+:8]}, 16'h5A00);
    chk("mode seg", {bm, sm}, 2'b11);
  endtask : s_bus
  task automatic s_alt;
    alt_out[96+:16] <= 16'h0005; alt_oe[96+:16] <= 16'h000E;
    bus(1'b1, 12'h0CC, 32'h000F);
    settle;
    chk("alt out", pin_out[97+:3], 3'h2);
    chk("alt oe", oe_n[96+:16], 16'hFFF1);
  endtask : s_alt
  task automatic s_misc;
    bus(1'b1, 12'h3F0, 32'hFFFF);
    rd(12'h3F0, 32'h0, "unmapped");
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("oe_n rst2", oe_n, {NPIN{1'b1}});
  endtask : s_misc
  task automatic summarize;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial begin
    #20000;
    err_total++;
    summarize;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_reset; s_dir; s_bit; s_od; s_thr; s_edge; s_bus; s_alt; s_misc;
    summarize;
  end
endmodule : tb_ppio_top
